// File: verilog/ufs_regs.sv
// How it works
// - Endpoint 8 flag register is read-only: bits 2..0 flags, upper zero.
// - Byte counts show OUT full count, IN bytes of current packet.
// - Endpoint 2 count is 13 bits, high byte holds bits 12..8.
// - Endpoint 6 count is 12 bits, high byte holds bits 11..8.
// - Endpoint 4 and 8 counts are 11 bits, high byte bits 10..8.
// - All eight count bytes are read-only and reset to zero.
// - Setup pointer holds 16-bit address; high byte writable.
// - Pointer low bit 0 always reads zero; firmware loads even addresses.
// - Auto-length resets to one; clear uses firmware length, not wLength.
// - Each received setup packet lands in a read-only eight-byte buffer.
// - Byte 0 bit 7 gives data stage direction.
// - Byte 0 bits 6..5 give request type.
// - Byte 0 bits 4..0 give recipient.
// - Byte 1 is request code; bytes 2 and 3 are wValue.
// - Bytes 4 and 5 are wIndex.
// - Bytes 6 and 7 are wLength.
//
// Chosen here: the APB slave port.
module ufs_regs
    import ufs_pkg::*;
(
    // Clock and reset.
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Endpoint FIFO state from the controller.
    input  wire logic [2:0]            ep8_flags_in,
    input  wire logic [EP2_CNT_W-1:0]  ep2_byte_count,
    input  wire logic [EP4_CNT_W-1:0]  ep4_byte_count,
    input  wire logic [EP6_CNT_W-1:0]  ep6_byte_count,
    input  wire logic [EP8_CNT_W-1:0]  ep8_byte_count,
    // Setup packet from the USB receiver, byte 0 in bits 7..0.
    input  wire logic                  setup_done,
    input  wire logic [63:0]           setup_packet,
    // Decoded setup fields and pointer control.
    output logic                       setup_dir_in,
    output logic [1:0]                 setup_req_type,
    output logic [4:0]                 setup_recipient,
    output logic [7:0]                 setup_request,
    output logic [15:0]                setup_value,
    output logic [15:0]                setup_index,
    output logic [15:0]                setup_length,
    output logic [15:0]                setup_data_pointer,
    output logic                       auto_length_enable,
    output logic [15:0]                data_stage_length,
    // Interrupt.
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [2:0]                  flags;
        logic [EP2_CNT_W-1:0]        cnt2;
        logic [EP4_CNT_W-1:0]        cnt4;
        logic [EP6_CNT_W-1:0]        cnt6;
        logic [EP8_CNT_W-1:0]        cnt8;
        logic [7:0]                  ptr_hi;
        logic [7:1]                  ptr_lo;
        logic                        auto_len;
        logic [15:0]                 fw_len;
        logic [SETUP_BYTES-1:0][7:0] buf_b;
        logic [INT_W-1:0]            int_stat;
        logic [INT_W-1:0]            int_mask;
        logic [31:0]                 rdata;
        logic                        ready;
        logic                        err;
        logic [15:0]                 dlen;
        logic                        irq;
    } ufs_state_s;

    ufs_state_s s_q;
    ufs_state_s s_d;

    logic [IDX_W-1:0] idx;
    logic             wr_en;
    logic             setup_ph;

    assign idx      = paddr[ADDR_W-1:2];
    assign setup_ph = psel && !penable;
    // A write lands only at the edge where the master sees pready high.
    assign wr_en    = psel && penable && s_q.ready && pwrite && pstrb[0];

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [7:0]       rbyte;
        logic             hit;
        logic [INT_W-1:0] ev;
        logic [INT_W-1:0] clr;
        rbyte = 8'h00;
        hit   = 1'b1;
        ev    = '0;
        clr   = '0;
        s_d   = s_q;

        // Live FIFO state is only sampled; software cannot alter it.
        s_d.flags = ep8_flags_in;
        s_d.cnt2  = ep2_byte_count;
        s_d.cnt4  = ep4_byte_count;
        s_d.cnt6  = ep6_byte_count;
        s_d.cnt8  = ep8_byte_count;

        // Interrupt events: new setup packet, FIFO turning full or empty.
        ev[INT_SETUP] = setup_done;
        ev[INT_FULL]  = ep8_flags_in[FLAG_FULL] && !s_q.flags[FLAG_FULL];
        ev[INT_EMPTY] = ep8_flags_in[FLAG_EMPTY]
                        && !s_q.flags[FLAG_EMPTY];

        // Whole packet is kept in wire order, low byte of each word first.
        if (setup_done) begin
            for (int i = 0; i < SETUP_BYTES; i++) begin
                s_d.buf_b[i] = setup_packet[8*i +: 8];
            end
        end

        if (wr_en) begin
            case (idx)
                IDX_PTR_HIGH:    s_d.ptr_hi   = pwdata[7:0];
                IDX_PTR_LOW:     s_d.ptr_lo   = pwdata[7:1];
                IDX_PTR_CONTROL: s_d.auto_len = pwdata[0];
                IDX_INT_MASK:    s_d.int_mask = pwdata[INT_W-1:0];
                IDX_INT_STATUS:  clr          = pwdata[INT_W-1:0];
                IDX_FW_LEN_LOW:  s_d.fw_len[7:0]  = pwdata[7:0];
                IDX_FW_LEN_HIGH: s_d.fw_len[15:8] = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // Setting wins over a simultaneous write-one-to-clear.
        s_d.int_stat = (s_q.int_stat & ~clr) | ev;
        s_d.irq      = |(s_d.int_stat & s_d.int_mask);

        // Firmware length replaces wLength while auto mode is off.
        s_d.dlen = s_d.auto_len ? {s_d.buf_b[7], s_d.buf_b[6]}
                                : s_d.fw_len;

        case (idx)
            IDX_EP8_FLAGS:      rbyte = {5'h00, s_q.flags};
            IDX_EP2_COUNT_HIGH: rbyte = {3'h0, s_q.cnt2[12:8]};
            IDX_EP2_COUNT_LOW:  rbyte = s_q.cnt2[7:0];
            IDX_EP4_COUNT_HIGH: rbyte = {5'h00, s_q.cnt4[10:8]};
            IDX_EP4_COUNT_LOW:  rbyte = s_q.cnt4[7:0];
            IDX_EP6_COUNT_HIGH: rbyte = {4'h0, s_q.cnt6[11:8]};
            IDX_EP6_COUNT_LOW:  rbyte = s_q.cnt6[7:0];
            IDX_EP8_COUNT_HIGH: rbyte = {5'h00, s_q.cnt8[10:8]};
            IDX_EP8_COUNT_LOW:  rbyte = s_q.cnt8[7:0];
            IDX_PTR_HIGH:       rbyte = s_q.ptr_hi;
            IDX_PTR_LOW:        rbyte = {s_q.ptr_lo, 1'b0};
            IDX_PTR_CONTROL:    rbyte = {7'h00, s_q.auto_len};
            IDX_INT_STATUS:     rbyte = {5'h00, s_q.int_stat};
            IDX_INT_MASK:       rbyte = {5'h00, s_q.int_mask};
            IDX_FW_LEN_LOW:     rbyte = s_q.fw_len[7:0];
            IDX_FW_LEN_HIGH:    rbyte = s_q.fw_len[15:8];
            default: begin
                // The setup buffer starts on an eight-word boundary.
                if (idx[IDX_W-1:3] == IDX_SETUP_BUF[IDX_W-1:3]) begin
                    rbyte = s_q.buf_b[idx[2:0]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end

        // Answer comes in the first access cycle; data is fixed in setup.
        s_d.ready = setup_ph;
        if (setup_ph) begin
            s_d.rdata = hit ? {24'h000000, rbyte} : 32'h00000000;
            s_d.err   = !hit;
        end else if (!psel) begin
            s_d.err   = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.flags    <= FLAGS_RST;
            s_q.ptr_hi   <= PTR_RST;
            s_q.auto_len <= AUTO_RST;
            s_q.fw_len   <= FW_LEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign prdata             = s_q.rdata;
    assign pready             = s_q.ready;
    assign pslverr            = s_q.err;
    assign setup_dir_in       = s_q.buf_b[0][RT_DIR];
    assign setup_req_type     = s_q.buf_b[0][RT_TYPE_HI:RT_TYPE_LO];
    assign setup_recipient    = s_q.buf_b[0][RT_RCPT_HI:RT_RCPT_LO];
    assign setup_request      = s_q.buf_b[1];
    assign setup_value        = {s_q.buf_b[3], s_q.buf_b[2]};
    assign setup_index        = {s_q.buf_b[5], s_q.buf_b[4]};
    assign setup_length       = {s_q.buf_b[7], s_q.buf_b[6]};
    assign setup_data_pointer = {s_q.ptr_hi, s_q.ptr_lo, 1'b0};
    assign auto_length_enable = s_q.auto_len;
    assign data_stage_length  = s_q.dlen;
    assign irq                = s_q.irq;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_setup;
    assign rd_setup = setup_ph && !pwrite && paddr[1:0] == 2'h0;

    property p_flags_read;
        rd_setup && idx == IDX_EP8_FLAGS
        |=> pready && !pslverr && prdata[31:3] == '0
            && prdata[2:0] == $past(s_q.flags);
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flag register read wrong");

    property p_count_follows;
        ##1 1 |-> s_q.cnt2 == $past(ep2_byte_count)
                  && s_q.cnt6 == $past(ep6_byte_count);
    endproperty
    a_count_follows: assert property (p_count_follows)
        else $error("byte count not tracking FIFO");

    property p_ep2_high;
        rd_setup && idx == IDX_EP2_COUNT_HIGH
        |=> prdata[31:5] == '0 && prdata[4:0] == $past(s_q.cnt2[12:8]);
    endproperty
    a_ep2_high: assert property (p_ep2_high)
        else $error("ep2 high byte wrong");

    property p_ep6_high;
        rd_setup && idx == IDX_EP6_COUNT_HIGH
        |=> prdata[31:4] == '0 && prdata[3:0] == $past(s_q.cnt6[11:8]);
    endproperty
    a_ep6_high: assert property (p_ep6_high)
        else $error("ep6 high byte wrong");

    property p_ep4_high;
        rd_setup && idx == IDX_EP4_COUNT_HIGH
        |=> prdata[31:3] == '0 && prdata[2:0] == $past(s_q.cnt4[10:8]);
    endproperty
    a_ep4_high: assert property (p_ep4_high)
        else $error("ep4 high byte wrong");

    property p_count_ro;
        wr_en && idx == IDX_EP8_COUNT_LOW
        |=> s_q.cnt8 == $past(ep8_byte_count);
    endproperty
    a_count_ro: assert property (p_count_ro)
        else $error("count register took a write");

    property p_ptr_high;
        wr_en && idx == IDX_PTR_HIGH
        |=> setup_data_pointer[15:8] == $past(pwdata[7:0]);
    endproperty
    a_ptr_high: assert property (p_ptr_high)
        else $error("pointer high byte not written");

    property p_ptr_even;
        wr_en && idx == IDX_PTR_LOW
        |=> setup_data_pointer[0] == 1'b0
            && setup_data_pointer[7:1] == $past(pwdata[7:1]);
    endproperty
    a_ptr_even: assert property (p_ptr_even)
        else $error("pointer low byte wrong");

    property p_auto_len;
        setup_done && s_d.auto_len
        |=> data_stage_length == $past(setup_packet[63:48]);
    endproperty
    a_auto_len: assert property (p_auto_len)
        else $error("auto length not from wLength");

    property p_fw_len;
        !s_q.auto_len && !wr_en |=> !s_q.auto_len
            |-> data_stage_length == s_q.fw_len;
    endproperty
    a_fw_len: assert property (p_fw_len)
        else $error("firmware length not used");

    property p_capture;
        setup_done |=> s_q.buf_b == $past(setup_packet);
    endproperty
    a_capture: assert property (p_capture)
        else $error("setup packet not captured");

    property p_decode;
        setup_done |=> setup_dir_in == $past(setup_packet[7])
            && setup_req_type == $past(setup_packet[6:5])
            && setup_recipient == $past(setup_packet[4:0]);
    endproperty
    a_decode: assert property (p_decode)
        else $error("request type decode wrong");

    property p_words;
        setup_done |=> setup_request == $past(setup_packet[15:8])
            && setup_value == $past(setup_packet[31:16])
            && setup_index == $past(setup_packet[47:32])
            && setup_length == $past(setup_packet[63:48]);
    endproperty
    a_words: assert property (p_words)
        else $error("setup word fields wrong");

    property p_low_first;
        rd_setup && idx == IDX_SETUP_BUF + 16'h0006
        |=> prdata[7:0] == $past(setup_length[7:0]);
    endproperty
    a_low_first: assert property (p_low_first)
        else $error("wLength low byte not at lower offset");

    property p_irq;
        ##1 1 |-> irq == $past(|(s_d.int_stat & s_d.int_mask));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level wrong");

    property p_set_wins;
        setup_done |=> s_q.int_stat[INT_SETUP];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("setup event lost");

    property p_cov_setup_read;
        setup_done ##[1:50] rd_setup && idx == IDX_SETUP_BUF;
    endproperty
    c_setup_read: cover property (p_cov_setup_read);

    property p_cov_irq;
        !irq ##1 irq;
    endproperty
    c_irq: cover property (p_cov_irq);

    property p_cov_fw_len;
        !s_q.auto_len && setup_done;
    endproperty
    c_fw_len: cover property (p_cov_fw_len);

    property p_cov_err;
        pready && pslverr;
    endproperty
    c_err: cover property (p_cov_err);

endmodule // ufs_regs

// File: inc/ufs_pkg.sv
package ufs_pkg;

    // Register bus geometry: each byte register owns one 32-bit word.
    localparam int ADDR_W = 18;
    localparam int IDX_W  = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_EP8_FLAGS      = 16'hE6AA;
    localparam logic [IDX_W-1:0] IDX_EP2_COUNT_HIGH = 16'hE6AB;
    localparam logic [IDX_W-1:0] IDX_EP2_COUNT_LOW  = 16'hE6AC;
    localparam logic [IDX_W-1:0] IDX_EP4_COUNT_HIGH = 16'hE6AD;
    localparam logic [IDX_W-1:0] IDX_EP4_COUNT_LOW  = 16'hE6AE;
    localparam logic [IDX_W-1:0] IDX_EP6_COUNT_HIGH = 16'hE6AF;
    localparam logic [IDX_W-1:0] IDX_EP6_COUNT_LOW  = 16'hE6B0;
    localparam logic [IDX_W-1:0] IDX_EP8_COUNT_HIGH = 16'hE6B1;
    localparam logic [IDX_W-1:0] IDX_EP8_COUNT_LOW  = 16'hE6B2;
    localparam logic [IDX_W-1:0] IDX_PTR_HIGH       = 16'hE6B3;
    localparam logic [IDX_W-1:0] IDX_PTR_LOW        = 16'hE6B4;
    localparam logic [IDX_W-1:0] IDX_PTR_CONTROL    = 16'hE6B5;
    localparam logic [IDX_W-1:0] IDX_SETUP_BUF      = 16'hE6B8;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS     = 16'hF000;
    localparam logic [IDX_W-1:0] IDX_INT_MASK       = 16'hF001;
    localparam logic [IDX_W-1:0] IDX_FW_LEN_LOW     = 16'hF002;
    localparam logic [IDX_W-1:0] IDX_FW_LEN_HIGH    = 16'hF003;

    // Widths of the byte counts, of the setup packet and of the interrupt registers.
    localparam int EP2_CNT_W   = 13;
    localparam int EP4_CNT_W   = 11;
    localparam int EP6_CNT_W   = 12;
    localparam int EP8_CNT_W   = 11;
    localparam int SETUP_BYTES = 8;
    localparam int INT_W       = 3;

    // Flag bit positions.
    localparam int FLAG_FULL  = 0;
    localparam int FLAG_EMPTY = 1;
    localparam int FLAG_PROG  = 2;

    // Interrupt status bit positions.
    localparam int INT_SETUP = 0;
    localparam int INT_FULL  = 1;
    localparam int INT_EMPTY = 2;

    // Request-type byte fields.
    localparam int RT_DIR     = 7;
    localparam int RT_TYPE_HI = 6;
    localparam int RT_TYPE_LO = 5;
    localparam int RT_RCPT_HI = 4;
    localparam int RT_RCPT_LO = 0;
    localparam logic [1:0] REQ_TYPE_STANDARD = 2'h0;
    localparam logic [1:0] REQ_TYPE_CLASS    = 2'h1;
    localparam logic [1:0] REQ_TYPE_VENDOR   = 2'h2;
    localparam logic [1:0] REQ_TYPE_RESERVED = 2'h3;
    localparam logic [4:0] RCPT_DEVICE       = 5'h00;
    localparam logic [4:0] RCPT_INTERFACE    = 5'h01;
    localparam logic [4:0] RCPT_ENDPOINT     = 5'h02;
    localparam logic [4:0] RCPT_OTHER        = 5'h03;

    // Values after reset.
    localparam logic [2:0]  FLAGS_RST    = 3'h6;
    localparam logic        AUTO_RST     = 1'b1;
    localparam logic [7:0]  PTR_RST      = 8'h00;
    localparam logic [15:0] FW_LEN_RST   = 16'h0000;

endpackage

// File: test/ufs_host_model.sv
module ufs_host_model
    import ufs_pkg::*;
(
    // Clock.
    input  wire logic        pclk,
    // Setup packet toward the block.
    output logic             setup_done,
    output logic [63:0]      setup_packet
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        setup_done   = 1'b0;
        setup_packet = 64'h0123456789ABCDEF;
    end

    // Each word field goes out low byte first, as on the bus.
    task automatic send(input logic [7:0] rtype, input logic [7:0] req,
                        input logic [15:0] val, input logic [15:0] idx,
                        input logic [15:0] len);
        @(posedge pclk);
        setup_done   <= 1'b1;
        setup_packet <= {len, idx, val, req, rtype};
        @(posedge pclk);
        setup_done   <= 1'b0;
        // The lines are not held after the strobe, so show a wrong value.
        setup_packet <= ~{len, idx, val, req, rtype};
    endtask
endmodule // ufs_host_model

// File: test/ufs_regs_tb.sv
module ufs_regs_tb
    import ufs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, setup_done, setup_dir_in, auto_length_enable, irq;
    logic [2:0] ep8_flags_in = 3'h6;
    logic [EP2_CNT_W-1:0] ep2_byte_count = '0;
    logic [EP4_CNT_W-1:0] ep4_byte_count = '0;
    logic [EP6_CNT_W-1:0] ep6_byte_count = '0;
    logic [EP8_CNT_W-1:0] ep8_byte_count = '0;
    logic [63:0] setup_packet;
    logic [1:0] setup_req_type;
    logic [4:0] setup_recipient;
    logic [7:0] setup_request;
    logic [15:0] setup_value, setup_index, setup_length;
    logic [15:0] setup_data_pointer, data_stage_length;
    int err_count = 0, checks = 0;

    always #50 pclk = ~pclk;

    ufs_regs u_ufs_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ep8_flags_in(ep8_flags_in), .ep2_byte_count(ep2_byte_count),
        .ep4_byte_count(ep4_byte_count), .ep6_byte_count(ep6_byte_count),
        .ep8_byte_count(ep8_byte_count), .setup_done(setup_done),
        .setup_packet(setup_packet), .setup_dir_in(setup_dir_in),
        .setup_req_type(setup_req_type), .setup_recipient(setup_recipient),
        .setup_request(setup_request), .setup_value(setup_value),
        .setup_index(setup_index), .setup_length(setup_length),
        .setup_data_pointer(setup_data_pointer),
        .auto_length_enable(auto_length_enable),
        .data_stage_length(data_stage_length), .irq(irq));

    ufs_host_model u_ufs_host_model (.pclk(pclk), .setup_done(setup_done),
        .setup_packet(setup_packet));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // The master never assumes a latency; it waits for pready.
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        if (n >= 20) begin
            chk(32'h0, 32'h1, "no pready");
        end
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        chk({31'h0, e}, 32'h0, "slave error");
        chk(r, {24'h000000, exp}, "register read");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(IDX_EP8_FLAGS, 8'h06);
        for (int i = 0; i < 8; i++) begin
            rd_chk(IDX_EP2_COUNT_HIGH + 16'(i), 8'h00);
        end
        rd_chk(IDX_PTR_CONTROL, 8'h01);
        chk({31'h0, auto_length_enable}, 32'h1, "auto after reset");
        $display("test reset done");
    endtask

    task automatic count_case(input logic [12:0] c2, input logic [10:0] c4,
                              input logic [11:0] c6, input logic [10:0] c8);
        @(posedge pclk);
        ep2_byte_count <= c2;
        ep4_byte_count <= c4;
        ep6_byte_count <= c6;
        ep8_byte_count <= c8;
        wr(IDX_EP2_COUNT_HIGH, 8'hFF);
        wr(IDX_EP8_FLAGS, 8'hFF);
        rd_chk(IDX_EP2_COUNT_HIGH, {3'h0, c2[12:8]});
        rd_chk(IDX_EP2_COUNT_LOW, c2[7:0]);
        rd_chk(IDX_EP4_COUNT_HIGH, {5'h00, c4[10:8]});
        rd_chk(IDX_EP4_COUNT_LOW, c4[7:0]);
        rd_chk(IDX_EP6_COUNT_HIGH, {4'h0, c6[11:8]});
        rd_chk(IDX_EP6_COUNT_LOW, c6[7:0]);
        rd_chk(IDX_EP8_COUNT_HIGH, {5'h00, c8[10:8]});
        rd_chk(IDX_EP8_COUNT_LOW, c8[7:0]);
        rd_chk(IDX_EP8_FLAGS, {5'h00, ep8_flags_in});
        $display("test counts done");
    endtask

    task automatic t_pointer();
        wr(IDX_PTR_HIGH, 8'hA5);
        wr(IDX_PTR_LOW, 8'h3F);
        rd_chk(IDX_PTR_HIGH, 8'hA5);
        rd_chk(IDX_PTR_LOW, 8'h3E);
        chk({16'h0, setup_data_pointer}, 32'hA53E, "pointer");
        $display("test pointer done");
    endtask

    task automatic t_setup();
        logic [7:0] b0;
        for (int t = 0; t < 4; t++) begin
            for (int r = 0; r < 4; r++) begin
                b0 = {1'(t), 2'(t), 5'(r)};
                u_ufs_host_model.send(b0, 8'(8'h10 + r), 16'h1234,
                                      16'h5678, 16'(16'h0040 + t));
                @(negedge pclk);
                chk({31'h0, setup_dir_in}, 32'(t % 2), "dir");
                chk({30'h0, setup_req_type}, 32'(t), "type");
                chk({27'h0, setup_recipient}, 32'(r), "recipient");
                chk({24'h0, setup_request}, 32'(8'h10 + r), "req");
                chk({16'h0, setup_value}, 32'h1234, "value");
                chk({16'h0, setup_index}, 32'h5678, "index");
                chk({16'h0, setup_length}, 32'(16'h40 + t), "len");
                chk({16'h0, data_stage_length}, 32'(16'h40 + t), "dsl");
            end
        end
        wr(IDX_SETUP_BUF, 8'hEE);
        rd_chk(IDX_SETUP_BUF, 8'hE3);
        rd_chk(IDX_SETUP_BUF + 16'h1, 8'h13);
        rd_chk(IDX_SETUP_BUF + 16'h2, 8'h34);
        rd_chk(IDX_SETUP_BUF + 16'h3, 8'h12);
        rd_chk(IDX_SETUP_BUF + 16'h4, 8'h78);
        rd_chk(IDX_SETUP_BUF + 16'h5, 8'h56);
        rd_chk(IDX_SETUP_BUF + 16'h6, 8'h43);
        rd_chk(IDX_SETUP_BUF + 16'h7, 8'h00);
        wr(IDX_FW_LEN_LOW, 8'h21);
        wr(IDX_FW_LEN_HIGH, 8'h03);
        wr(IDX_PTR_CONTROL, 8'h00);
        rd_chk(IDX_PTR_CONTROL, 8'h00);
        chk({16'h0, data_stage_length}, 32'h0321, "fw length");
        $display("test setup done");
    endtask

    task automatic t_irq();
        logic [31:0] r;
        logic        e;
        wr(IDX_INT_MASK, 8'h01);
        u_ufs_host_model.send(8'h80, 8'h06, 16'h0100, 16'h0000, 16'h0012);
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1, "irq on setup");
        rd_chk(IDX_INT_STATUS, 8'h01);
        wr(IDX_INT_STATUS, 8'h01);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(IDX_INT_MASK, 8'h00);
        ep8_flags_in <= 3'h1;
        @(negedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "masked event");
        rd_chk(IDX_INT_STATUS, 8'h02);
        wr(IDX_INT_MASK, 8'h02);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1, "unmasked event");
        wr(IDX_INT_STATUS, 8'h02);
        rd_chk(IDX_INT_STATUS, 8'h00);
        apb(1'b0, 16'h0100, 8'h00, r, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        $display("test irq done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        count_case(13'h1000, 11'h400, 12'h800, 11'h400);
        count_case(13'h0ABC, 11'h3A5, 12'h7CD, 11'h2FF);
        t_pointer();
        t_setup();
        t_irq();
        report_and_stop();
    end

    // The tests take under 250 cycles; the limit of 10000 cycles allows forty times that.
    initial begin
        #1000000;
        err_count++;
        report_and_stop();
    end
endmodule // ufs_regs_tb
